// File: rtl/dsr_regs.vh
// register indices, status bit positions and protocol codes of the bank
`ifndef DSR_REGS_VH
`define DSR_REGS_VH

// holding register indices
`define DSR_HR_STATUS 16'h0000
`define DSR_HR_SPEED 16'h0001
`define DSR_HR_POS_HI 16'h0002
`define DSR_HR_POS_LO 16'h0003
`define DSR_HR_TORQUE 16'h0004
`define DSR_HR_PEAK 16'h0005
`define DSR_HR_LIMIT 16'h0100

// status word bit positions
`define DSR_ST_REACHED 0
`define DSR_ST_DRAG 1
`define DSR_ST_JOG_REV 2
`define DSR_ST_JOG_FWD 3
`define DSR_ST_PWR_NOW 4
`define DSR_ST_ABORT 5
`define DSR_ST_RUNNING 6
`define DSR_ST_OVERTEMP 7
`define DSR_ST_AGAINST 8
`define DSR_ST_ENC_ERR 9
`define DSR_ST_BLOCKED 10
`define DSR_ST_HAND 11
`define DSR_ST_BAD_TGT 12
`define DSR_ST_PWR_LOST 13
`define DSR_ST_LIM_POS 14
`define DSR_ST_LIM_NEG 15

// function codes
`define DSR_FC_READ 8'h03
`define DSR_FC_WRITE1 8'h06
`define DSR_FC_WRITEN 8'h10

// answer codes
`define DSR_EX_NONE 8'h00
`define DSR_EX_FUNC 8'h01
`define DSR_EX_ADDR 8'h02
`define DSR_EX_VALUE 8'h03

// reset values
`define DSR_RST_WORD 16'h0000
`define DSR_RST_LONG 32'h0000_0000

`endif

// File: rtl/dsr_bank.v
// holding register bank of the positioning drive: status, speed, position
//
// Notes on behaviour
// - status word at index 0; reached, running
// - bits 2 and 3 follow jog keys
// - bit 4 power now, bit 13 was lost
// - drag, abort, overtemp, blocked fault bits
// - against loop direction, manual displacement flags
// - bit 12 flags unacceptable target value
// - bits 14 and 15 travel limits
// - signed position, high word index 2, low 3
// - writing position pair rebases without moving
// - index 5 holds peak torque of run
// - peak ignores start and braking phases
// - high then low word; else reject low
// - after target, encoder mismatch sets bit 9
// - functions 03, 06 and 10 supported
`timescale 1ns/100ps
`include "dsr_regs.vh"

module dsr_bank (
  input wire core_clk_i, // 250 MHz core clock
  input wire rst_n_i, // asynchronous reset, active low
  input wire req_valid_i, // one-cycle pulse: decoded register access
  input wire [7:0] req_func_i, // function code of the frame
  input wire [15:0] req_addr_i, // holding_register_index of this word
  input wire [15:0] req_wdata_i, // word to write
  output reg rsp_valid_o, // one-cycle pulse: answer ready
  output reg [15:0] rsp_rdata_o, // read data
  output reg [7:0] rsp_exc_o, // answer code, 0 = none; held between answers
  input wire jog_rev_pin_i, // reverse jog key pin, active high
  input wire jog_fwd_pin_i, // forward jog key pin, active high
  input wire motor_pwr_pin_i, // motor supply present pin
  input wire target_reached_i, // level from sequencer
  input wire running_i, // level: drive moving
  input wire drag_err_i, // pulse: following deviation
  input wire run_abort_i, // pulse: run aborted
  input wire overtemp_i, // level: temperature exceeded
  input wire against_dir_i, // pulse: move opposite approach direction
  input wire blocked_i, // pulse: positioning blocked
  input wire hand_disp_i, // pulse: output displaced by hand
  input wire bad_target_i, // pulse: target value rejected
  input wire lim_pos_i, // level: upper travel limit
  input wire lim_neg_i, // level: lower travel limit
  input wire [31:0] raw_pos_i, // internal position count
  input wire [31:0] enc_pos_i, // absolute encoder position
  input wire [15:0] speed_i, // signed speed in rpm
  input wire [15:0] torque_i, // torque in cNm
  input wire start_phase_i, // level: start-up torque phase
  input wire decel_phase_i, // level: braking phase
  output reg [31:0] pos_o // rebased position, 1/100 mm
);

  // ==========================================================
  // pin synchronisers
  reg [2:0] pin_s1_r;
  reg [2:0] pin_s2_r;

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
    end else begin
      pin_s1_r <= {motor_pwr_pin_i, jog_fwd_pin_i, jog_rev_pin_i};
      pin_s2_r <= pin_s1_r;
    end
  end

  wire jog_rev = pin_s2_r[0];
  wire jog_fwd = pin_s2_r[1];
  wire pwr_now = pin_s2_r[2];

  // the second stage holds a real pin sample only two edges after reset;
  // until then its cleared value must not read as a supply loss
  reg [1:0] sync_vld_r;
  wire sync_ok = sync_vld_r[1];

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_vld_r <= 2'h0;
    end else begin
      sync_vld_r <= {sync_vld_r[0], 1'b1};
    end
  end

  // ==========================================================
  // run edges
  reg running_d_r;
  reg reached_d_r;

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      running_d_r <= 1'b0;
      reached_d_r <= 1'b0;
    end else begin
      running_d_r <= running_i;
      reached_d_r <= target_reached_i;
    end
  end

  wire run_start = running_i & ~running_d_r;
  wire reach_rise = target_reached_i & ~reached_d_r;

  // ==========================================================
  // sticky fault flags, cleared when a new run starts; set wins
  localparam NSTK = 8;
  wire [NSTK-1:0] stk_set;
  reg [NSTK-1:0] stk_r;
  wire [NSTK-1:0] stk_nxt;
  wire [31:0] enc_diff;

  assign enc_diff = raw_pos_i - enc_pos_i;
  assign stk_set[0] = drag_err_i;
  assign stk_set[1] = run_abort_i;
  assign stk_set[2] = against_dir_i;
  assign stk_set[3] = reach_rise & (enc_diff != 32'h0000_0000);
  assign stk_set[4] = blocked_i;
  assign stk_set[5] = hand_disp_i;
  assign stk_set[6] = bad_target_i;
  assign stk_set[7] = sync_ok & ~pwr_now;

  genvar gi;
  generate
    for (gi = 0; gi < NSTK; gi = gi + 1) begin : g_stk
      // a cause in the run-start cycle survives the clear
      assign stk_nxt[gi] = stk_set[gi] | (stk_r[gi] & ~run_start);
    end
  endgenerate

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stk_r <= 8'h00;
    end else begin
      stk_r <= stk_nxt;
    end
  end

  // ==========================================================
  // status word
  reg [15:0] status;

  always @* begin
    status = 16'h0000;
    status[`DSR_ST_REACHED] = target_reached_i;
    status[`DSR_ST_RUNNING] = running_i;
    status[`DSR_ST_JOG_REV] = jog_rev;
    status[`DSR_ST_JOG_FWD] = jog_fwd;
    status[`DSR_ST_PWR_NOW] = pwr_now;
    status[`DSR_ST_PWR_LOST] = stk_r[7];
    status[`DSR_ST_DRAG] = stk_r[0];
    status[`DSR_ST_ABORT] = stk_r[1];
    status[`DSR_ST_OVERTEMP] = overtemp_i;
    status[`DSR_ST_BLOCKED] = stk_r[4];
    status[`DSR_ST_AGAINST] = stk_r[2];
    status[`DSR_ST_HAND] = stk_r[5];
    status[`DSR_ST_BAD_TGT] = stk_r[6];
    status[`DSR_ST_ENC_ERR] = stk_r[3];
    status[`DSR_ST_LIM_POS] = lim_pos_i;
    status[`DSR_ST_LIM_NEG] = lim_neg_i;
  end

  // ==========================================================
  // peak torque of the current or last run
  reg [15:0] peak_r;
  reg [15:0] peak_nxt;
  wire peak_win = running_i & ~start_phase_i & ~decel_phase_i;

  // cleared at run start, so a read during a run shows its peak so far
  always @* begin
    peak_nxt = peak_r;
    if (run_start) begin
      peak_nxt = `DSR_RST_WORD;
    end else if (peak_win && (torque_i > peak_r)) begin
      peak_nxt = torque_i;
    end
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      peak_r <= `DSR_RST_WORD;
    end else begin
      peak_r <= peak_nxt;
    end
  end

  // ==========================================================
  // register access decode
  reg [31:0] offset_r;
  reg [15:0] hi_hold_r;
  reg hi_pend_r;

  reg is_read;
  reg is_write;

  always @* begin
    is_read = 1'b0;
    is_write = 1'b0;
    case (req_func_i)
      `DSR_FC_READ: is_read = 1'b1;
      `DSR_FC_WRITE1: is_write = 1'b1;
      `DSR_FC_WRITEN: is_write = 1'b1;
      default: is_write = 1'b0;
    endcase
  end

  // indices at or above the limit are refused; below it unknown ones
  // take writes silently and read as zero
  wire addr_ok = (req_addr_i < `DSR_HR_LIMIT);
  wire wr_hi = (req_addr_i == `DSR_HR_POS_HI);
  wire wr_lo = (req_addr_i == `DSR_HR_POS_LO);
  wire [31:0] new_pos = {hi_hold_r, req_wdata_i};
  wire [31:0] cur_pos = raw_pos_i + offset_r;

  // the pair is read live: two reads while the axis moves
  // may pair halves from different cycles
  reg [15:0] rd_word;

  always @* begin
    case (req_addr_i)
      `DSR_HR_STATUS: rd_word = status;
      `DSR_HR_SPEED: rd_word = speed_i;
      `DSR_HR_POS_HI: rd_word = cur_pos[31:16];
      `DSR_HR_POS_LO: rd_word = cur_pos[15:0];
      `DSR_HR_TORQUE: rd_word = torque_i;
      `DSR_HR_PEAK: rd_word = peak_r;
      default: rd_word = 16'h0000;
    endcase
  end

  // ==========================================================
  // answer next state
  reg rsp_valid_nxt;
  reg [15:0] rsp_rdata_nxt;
  reg [7:0] rsp_exc_nxt;
  reg [31:0] offset_nxt;
  reg [15:0] hi_hold_nxt;
  reg hi_pend_nxt;

  always @* begin
    rsp_valid_nxt = req_valid_i;
    rsp_rdata_nxt = rsp_rdata_o;
    rsp_exc_nxt = rsp_exc_o;
    offset_nxt = offset_r;
    hi_hold_nxt = hi_hold_r;
    hi_pend_nxt = hi_pend_r;
    if (req_valid_i) begin
      rsp_rdata_nxt = 16'h0000;
      rsp_exc_nxt = `DSR_EX_NONE;
      if (!is_read && !is_write) begin
        rsp_exc_nxt = `DSR_EX_FUNC;
      end else if (!addr_ok) begin
        rsp_exc_nxt = `DSR_EX_ADDR;
      end else if (is_read) begin
        rsp_rdata_nxt = rd_word;
      end else if (wr_hi) begin
        hi_hold_nxt = req_wdata_i;
        hi_pend_nxt = 1'b1;
      end else if (wr_lo) begin
        // the low word always ends a pair, committed or refused
        hi_pend_nxt = 1'b0;
        if (hi_pend_r) begin
          offset_nxt = new_pos - raw_pos_i;
        end else begin
          rsp_exc_nxt = `DSR_EX_VALUE;
        end
      end else begin
        // a write to any other index below the limit breaks an open pair
        hi_pend_nxt = 1'b0;
      end
    end
  end

  // ==========================================================
  // answer registers
  // every answer field is a flop, one cycle after the request
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= `DSR_RST_WORD;
      rsp_exc_o <= `DSR_EX_NONE;
      offset_r <= `DSR_RST_LONG;
      hi_hold_r <= `DSR_RST_WORD;
      hi_pend_r <= 1'b0;
    end else begin
      rsp_valid_o <= rsp_valid_nxt;
      rsp_rdata_o <= rsp_rdata_nxt;
      rsp_exc_o <= rsp_exc_nxt;
      offset_r <= offset_nxt;
      hi_hold_r <= hi_hold_nxt;
      hi_pend_r <= hi_pend_nxt;
    end
  end

  // ==========================================================
  // position output
  // registered so a consumer sees one settled word per cycle
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pos_o <= `DSR_RST_LONG;
    end else begin
      pos_o <= cur_pos;
    end
  end

endmodule

// File: dv/dsr_bank_properties.sv
// port-level properties of the drive status register bank
`timescale 1ns/100ps
module dsr_bank_properties (
  input wire core_clk_i, // core clock
  input wire rst_n_i, // reset, active low
  input wire req_valid_i, // request strobe
  input wire [7:0] req_func_i, // function code
  input wire [15:0] req_addr_i, // register index
  input wire rsp_valid_o, // answer strobe
  input wire [15:0] rsp_rdata_o, // read data
  input wire [7:0] rsp_exc_o, // answer code
  input wire target_reached_i, // reached level
  input wire running_i, // running level
  input wire [15:0] speed_i, // speed
  input wire [15:0] torque_i // torque
);
  wire fok = req_func_i == 8'h03 || req_func_i == 8'h06 ||
    req_func_i == 8'h10;
  wire low = req_addr_i[15:8] == 8'h00;
  wire rd = req_valid_i && req_func_i == 8'h03 && low;
  wire wr = req_valid_i && fok && req_func_i != 8'h03 && low;
  reg pend_r;
  // tracks a latched high position word
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      pend_r <= 1'b0;
    else if (wr)
      pend_r <= req_addr_i == 16'h0002;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_answer_late: assert property (rsp_valid_o == $past(req_valid_i))
    else $error("answer strobe not one cycle after request");
  a_func_refused: assert property (req_valid_i && !fok |=>
    rsp_exc_o == 8'h01) else $error("bad function not refused");
  a_addr_refused: assert property (req_valid_i && fok && !low |=>
    rsp_exc_o == 8'h02) else $error("high address not refused");
  a_status_live: assert property (rd && req_addr_i == 16'h0000 |=>
    rsp_rdata_o[0] == $past(target_reached_i) &&
    rsp_rdata_o[6] == $past(running_i)) else $error("status levels wrong");
  a_speed_read: assert property (rd && req_addr_i == 16'h0001 |=>
    rsp_rdata_o == $past(speed_i)) else $error("speed read wrong");
  a_torque_read: assert property (rd && req_addr_i == 16'h0004 |=>
    rsp_rdata_o == $past(torque_i)) else $error("torque read wrong");
  a_orphan_low: assert property (wr && req_addr_i == 16'h0003 &&
    !pend_r |=> rsp_exc_o == 8'h03) else $error("orphan low accepted");
  a_pair_commit: assert property (wr && req_addr_i == 16'h0003 &&
    pend_r |=> rsp_exc_o == 8'h00) else $error("paired low refused");
  a_write_quiet: assert property (wr && req_addr_i != 16'h0003 |=>
    rsp_exc_o == 8'h00 && rsp_rdata_o == 16'h0000)
    else $error("plain write answer wrong");
  c_status: cover property (rd && req_addr_i == 16'h0000);
  c_orphan: cover property (wr && req_addr_i == 16'h0003 && !pend_r);
  c_badfunc: cover property (req_valid_i && !fok);
endmodule
bind dsr_bank dsr_bank_properties u_dsr_bank_properties (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
  .req_func_i(req_func_i), .req_addr_i(req_addr_i),
  .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
  .rsp_exc_o(rsp_exc_o), .target_reached_i(target_reached_i),
  .running_i(running_i), .speed_i(speed_i), .torque_i(torque_i));

// File: dv/dsr_master_model.sv
// bus master model issuing decoded register word accesses
`timescale 1ns/100ps
module dsr_master_model (
  input wire core_clk_i, // core clock
  output reg req_valid_o, // request strobe
  output reg [7:0] req_func_o, // function code
  output reg [15:0] req_addr_o, // register index
  output reg [15:0] req_wdata_o, // write word
  input wire rsp_valid_i, // answer strobe
  input wire [15:0] rsp_rdata_i, // read data
  input wire [7:0] rsp_exc_i // answer code
);
  initial begin
    req_valid_o = 1'b0;
    req_func_o = 8'h00;
    req_addr_o = 16'h0000;
    req_wdata_o = 16'h0000;
  end
  task xfer(input [7:0] f, input [15:0] a, input [15:0] d,
    output [15:0] rd, output [7:0] ex, output ok);
    integer n;
    begin
      @(posedge core_clk_i);
      #1;
      req_func_o = f;
      req_addr_o = a;
      req_wdata_o = d;
      req_valid_o = 1'b1;
      @(posedge core_clk_i);
      #1;
      req_valid_o = 1'b0;
      // idle lines must not keep the last value
      req_func_o = ~f;
      req_addr_o = ~a;
      req_wdata_o = ~d;
      ok = 1'b0;
      for (n = 0; n < 4 && !ok; n = n + 1) begin
        if (rsp_valid_i === 1'b1) begin
          ok = 1'b1;
          rd = rsp_rdata_i;
          ex = rsp_exc_i;
        end else begin
          @(posedge core_clk_i);
          #1;
        end
      end
    end
  endtask
endmodule

// File: dv/dsr_bank_tb.sv
// self-checking bench of the drive status register bank
`timescale 1ns/100ps
module dsr_bank_tb;
  reg clk = 1'b0, rst_n = 1'b0, tr = 1'b0, run = 1'b0, ot = 1'b0;
  reg lp = 1'b0, ln = 1'b0, jr = 1'b0, jf = 1'b0, pw = 1'b1;
  reg sp = 1'b0, dp = 1'b0;
  reg [5:0] pul = 6'h00;
  reg [31:0] raw = 32'h1234_5678, enc = 32'h1234_5678;
  reg [15:0] spd = 16'h8123, trq = 16'h0ABC;
  wire rv, vi;
  wire [15:0] rdat, ai, di;
  wire [7:0] rexc, fi;
  wire [31:0] pos;
  integer err_count = 0, samples_checked = 0;
  initial forever #2 clk = ~clk;
  dsr_master_model u_dsr_master_model (.core_clk_i(clk), .req_valid_o(vi),
    .req_func_o(fi), .req_addr_o(ai), .req_wdata_o(di),
    .rsp_valid_i(rv), .rsp_rdata_i(rdat), .rsp_exc_i(rexc));
  dsr_bank u_dsr_bank (.core_clk_i(clk), .rst_n_i(rst_n),
    .req_valid_i(vi), .req_func_i(fi), .req_addr_i(ai), .req_wdata_i(di),
    .rsp_valid_o(rv), .rsp_rdata_o(rdat), .rsp_exc_o(rexc),
    .jog_rev_pin_i(jr), .jog_fwd_pin_i(jf), .motor_pwr_pin_i(pw),
    .target_reached_i(tr), .running_i(run), .drag_err_i(pul[0]),
    .run_abort_i(pul[1]), .overtemp_i(ot), .against_dir_i(pul[2]),
    .blocked_i(pul[3]), .hand_disp_i(pul[4]), .bad_target_i(pul[5]),
    .lim_pos_i(lp), .lim_neg_i(ln), .raw_pos_i(raw), .enc_pos_i(enc),
    .speed_i(spd), .torque_i(trq), .start_phase_i(sp),
    .decel_phase_i(dp), .pos_o(pos));
  task close_out;
    begin
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [31:0] e, input [31:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("BAD t=%0t exp %h got %h", $time, e, g);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task acc(input [7:0] f, input [15:0] a, d, er, input [7:0] ee);
    reg [15:0] r;
    reg [7:0] x;
    reg ok;
    begin
      u_dsr_master_model.xfer(f, a, d, r, x, ok);
      if (!ok) begin
        err_count = err_count + 1;
        close_out;
      end else begin
        chk({16'h0000, er}, {16'h0000, r});
        chk({24'h000000, ee}, {24'h000000, x});
      end
    end
  endtask
  initial begin
    cyc(6);
    rst_n = 1'b1;
    cyc(3);
    acc(8'h03, 16'h0000, 16'h0000, 16'h0010, 8'h00);
    acc(8'h03, 16'h0001, 16'h0000, 16'h8123, 8'h00);
    acc(8'h03, 16'h0002, 16'h0000, 16'h1234, 8'h00);
    acc(8'h03, 16'h0003, 16'h0000, 16'h5678, 8'h00);
    acc(8'h03, 16'h0004, 16'h0000, 16'h0ABC, 8'h00);
    acc(8'h03, 16'h0005, 16'h0000, 16'h0000, 8'h00);
    {tr, ot, lp, ln, jr, jf} = 6'h3F;
    cyc(3);
    acc(8'h03, 16'h0000, 16'h0000, 16'hC09D, 8'h00);
    tr = 1'b0;
    enc = 32'h0000_0000;
    cyc(1);
    tr = 1'b1;
    pul = 6'h3F;
    pw = 1'b0;
    cyc(1);
    pul = 6'h00;
    cyc(4);
    pw = 1'b1;
    cyc(4);
    acc(8'h03, 16'h0000, 16'h0000, 16'hFFBF, 8'h00);
    tr = 1'b0;
    enc = raw;
    {run, sp, trq} = {2'b11, 16'h0384};
    cyc(2);
    acc(8'h03, 16'h0000, 16'h0000, 16'hC0DC, 8'h00);
    {sp, trq} = {1'b0, 16'h012C};
    cyc(1);
    trq = 16'h01F4;
    cyc(1);
    trq = 16'h00C8;
    cyc(1);
    {dp, trq} = {1'b1, 16'h0320};
    cyc(2);
    run = 1'b0;
    cyc(1);
    dp = 1'b0;
    acc(8'h03, 16'h0005, 16'h0000, 16'h01F4, 8'h00);
    acc(8'h10, 16'h0002, 16'hFFFF, 16'h0000, 8'h00);
    acc(8'h10, 16'h0003, 16'hFF00, 16'h0000, 8'h00);
    cyc(2);
    chk(32'hFFFF_FF00, pos);
    acc(8'h03, 16'h0002, 16'h0000, 16'hFFFF, 8'h00);
    acc(8'h06, 16'h0003, 16'h0000, 16'h0000, 8'h03);
    acc(8'h10, 16'h0002, 16'h0001, 16'h0000, 8'h00);
    acc(8'h06, 16'h0000, 16'h0000, 16'h0000, 8'h00);
    acc(8'h10, 16'h0003, 16'h0002, 16'h0000, 8'h03);
    acc(8'h03, 16'h0003, 16'h0000, 16'hFF00, 8'h00);
    acc(8'h04, 16'h0000, 16'h0000, 16'h0000, 8'h01);
    acc(8'h2B, 16'h0000, 16'h0000, 16'h0000, 8'h01);
    acc(8'h03, 16'h0100, 16'h0000, 16'h0000, 8'h02);
    acc(8'h06, 16'h0100, 16'h0000, 16'h0000, 8'h02);
    acc(8'h03, 16'h0010, 16'h0000, 16'h0000, 8'h00);
    pul = 6'h15;
    cyc(1);
    pul = 6'h00;
    cyc(1);
    acc(8'h03, 16'h0000, 16'h0000, 16'hC99E, 8'h00);
    {run, pul} = {1'b1, 6'h2A};
    cyc(1);
    pul = 6'h00;
    cyc(1);
    acc(8'h03, 16'h0000, 16'h0000, 16'hD4FC, 8'h00);
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc(3);
    acc(8'h03, 16'h0000, 16'h0000, 16'hC0DC, 8'h00);
    acc(8'h03, 16'h0002, 16'h0000, 16'h1234, 8'h00);
    acc(8'h10, 16'h0003, 16'h0005, 16'h0000, 8'h03);
    close_out;
  end
endmodule
